/* File: src/ecp_pkg.sv */
package ecp_pkg;

  // ---------------------------------------------------------------
  // Serial frame
  // ---------------------------------------------------------------
  localparam int FRAME_BITS = 16;
  localparam int COMMIT_CLOCKS = 4;

  // Configuration word layout, MSB first on the serial line
  typedef struct packed {
    logic [7:0] acoustic_return_loss_threshold; // Bits 15:8
    logic [1:0] spare;                          // Bits 7:6
    logic network_ec_disable;                   // Bit 5
    logic half_duplex_disable;                  // Bit 4
    logic rx_suppression_disable;               // Bit 3
    logic tx_suppression_disable;               // Bit 2
    logic network_coef_clear;                   // Bit 1
    logic acoustic_coef_clear;                  // Bit 0
  } ecp_config_t;

  localparam logic [15:0] CONFIG_RESET = 16'h4000;

  // Block outputs towards the echo-cancelling core
  typedef struct packed {
    logic block_enable;
    logic full_duplex;
    logic acoustic_adapt;
    logic network_adapt;
    logic network_ec_enable;
    logic tx_suppression_enable;
    logic rx_suppression_enable;
  } ecp_ctrl_t;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_CONFIG = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_CONTROL = 4'h8;
  localparam int CTRL_PORT_ENABLE_BIT = 0;
  localparam int CTRL_RETRAIN_BIT = 1;
  localparam logic [1:0] CONTROL_RESET = 2'h1;

  // ---------------------------------------------------------------
  // Training
  // ---------------------------------------------------------------
  localparam int TRAIN_UTTERANCES = 3;

  typedef enum logic [1:0] {
    ECP_IDLE = 2'b00,
    ECP_HALF = 2'b01,
    ECP_FULL = 2'b10
  } ecp_duplex_t;

endpackage : ecp_pkg

/* File: src/ecp_control_port.sv */
`timescale 1ns/1ps
module ecp_control_port #(
  parameter int FRAME_W = ecp_pkg::FRAME_BITS,
  parameter int COMMIT_N = ecp_pkg::COMMIT_CLOCKS,
  parameter int UTTER_N = ecp_pkg::TRAIN_UTTERANCES
) (
  input wire logic core_clk, // Core clock, 200 MHz
  input wire logic rst_n, // Async reset, active low
  input wire logic strobe_clk, // Serial strobe from controller
  input wire logic serial_data, // Serial data bit
  input wire logic data_valid_n, // Transfer gate, active low
  input wire logic utterance_done, // Pulse per utterance trained
  input wire logic [7:0] measured_return_loss, // Acoustic ERLE
  input wire logic [3:0] avs_address, // Avalon byte address
  input wire logic avs_read, // Avalon read
  input wire logic avs_write, // Avalon write
  input wire logic [3:0] avs_byteenable, // Avalon byte enables
  input wire logic [31:0] avs_writedata, // Avalon write data
  output logic [31:0] avs_readdata, // Avalon read data
  output logic avs_waitrequest, // Avalon wait
  output ecp_pkg::ecp_ctrl_t ctrl, // Enables to the core
  output logic [7:0] return_loss_threshold // Switch level
);

  initial begin
    if (FRAME_W != $bits(ecp_pkg::ecp_config_t) || COMMIT_N < 1 ||
        COMMIT_N > 255 || UTTER_N < 1 || UTTER_N > 255) begin
      $error("ecp_control_port: unsupported parameters");
    end
  end

  localparam int BCW = $clog2(FRAME_W + 2);
  localparam logic [BCW-1:0] FULL_CNT = BCW'(FRAME_W);
  localparam logic [BCW-1:0] OVER_CNT = BCW'(FRAME_W + 1);
  localparam logic [7:0] LAST_COMMIT = 8'(COMMIT_N - 1);
  localparam logic [7:0] UTTER_MAX = 8'(UTTER_N);

  // ---------------------------------------------------------------
  // Strobe domain: shifting and commit
  // ---------------------------------------------------------------
  logic [FRAME_W-1:0] shift_reg;
  logic [FRAME_W-1:0] frame_word;
  logic [BCW-1:0] bit_cnt;
  logic [7:0] commit_cnt;
  logic gate_was_low;
  logic commit_toggle;

  // Bits shift only while the gate is low; strobe also runs on the idle commit edges after frames
  always_ff @(posedge strobe_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= '0;
      bit_cnt <= '0;
      gate_was_low <= 1'b0;
    end else begin
      gate_was_low <= !data_valid_n;
      if (!data_valid_n) begin
        shift_reg <= {shift_reg[FRAME_W-2:0], serial_data};
        if (!gate_was_low) begin
          bit_cnt <= BCW'(1); // Fresh frame drops any earlier part
        end else if (bit_cnt != OVER_CNT) begin
          bit_cnt <= bit_cnt + BCW'(1);
        end
      end
    end
  end

  // Commit after exactly a full frame and the extra gate-high edges
  always_ff @(posedge strobe_clk or negedge rst_n) begin
    if (!rst_n) begin
      commit_cnt <= '0;
      frame_word <= '0;
      commit_toggle <= 1'b0;
    end else if (!data_valid_n) begin
      commit_cnt <= '0; // Gate fell before commit: abandon
    end else if (gate_was_low && bit_cnt != FULL_CNT) begin
      commit_cnt <= '0; // Short or long frame never commits
    end else if (bit_cnt == FULL_CNT && commit_cnt != 8'hFF) begin
      // Idle edges count up; the last one loads the word and toggles
      if (commit_cnt == LAST_COMMIT) begin
        frame_word <= shift_reg;
        commit_toggle <= ~commit_toggle;
        commit_cnt <= 8'hFF;
      end else begin
        commit_cnt <= commit_cnt + 8'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // Crossing into the core domain
  // ---------------------------------------------------------------
  logic tog_s1;
  logic tog_s2;
  logic tog_s3;
  logic tog_seen;
  logic frame_event;

  // Word is held still until the next full frame, so a toggle suffices
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
      tog_s3 <= 1'b0;
      tog_seen <= 1'b0;
    end else begin
      tog_s1 <= commit_toggle;
      tog_s2 <= tog_s1;
      tog_s3 <= tog_s2;
      if (tog_s2 == tog_s3) begin
        tog_seen <= tog_s3;
      end
    end
  end

  assign frame_event = (tog_s2 == tog_s3) && (tog_s3 != tog_seen);

  // ---------------------------------------------------------------
  // Configuration and software control
  // ---------------------------------------------------------------
  ecp_pkg::ecp_config_t cfg;
  logic port_enable;
  logic retrain_req;
  logic [7:0] frames_taken;

  // Committed frames land here unless software has closed the port
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= ecp_pkg::CONFIG_RESET;
      frames_taken <= '0;
    end else if (frame_event && port_enable) begin
      cfg <= frame_word;
      frames_taken <= frames_taken + 8'h01;
    end
  end

  // Control register: port enable level, retrain as a pulse
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_enable <= ecp_pkg::CONTROL_RESET[0];
      retrain_req <= ecp_pkg::CONTROL_RESET[1];
    end else begin
      retrain_req <= 1'b0;
      if (bus_write_hit(avs_write, avs_waitrequest, avs_address,
                        ecp_pkg::REG_CONTROL) && avs_byteenable[0]) begin
        port_enable <= avs_writedata[ecp_pkg::CTRL_PORT_ENABLE_BIT];
        retrain_req <= avs_writedata[ecp_pkg::CTRL_RETRAIN_BIT];
      end
    end
  end

  function automatic logic bus_write_hit(input logic wr, input logic wt,
                                         input logic [3:0] addr,
                                         input logic [3:0] target);
    bus_write_hit = wr && !wt && (addr == target);
  endfunction : bus_write_hit

  // ---------------------------------------------------------------
  // Training and duplex state
  // ---------------------------------------------------------------
  ecp_pkg::ecp_duplex_t state;
  ecp_pkg::ecp_duplex_t next_state;
  logic [7:0] utter_cnt;
  logic both_cleared;
  logic trained;

  assign both_cleared = cfg.acoustic_coef_clear && cfg.network_coef_clear;
  assign trained = (utter_cnt == UTTER_MAX);

  // Clearing acoustic coefficients or a retrain restarts the training count
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      utter_cnt <= '0;
    end else if (cfg.acoustic_coef_clear || retrain_req) begin
      utter_cnt <= '0; // Adaptation restarts from scratch
    end else if (utterance_done && !trained) begin
      utter_cnt <= utter_cnt + 8'h01;
    end
  end

  // Half-duplex disable overrides training, cleared sets override all
  always_comb begin
    next_state = state;
    case (state)
      ecp_pkg::ECP_IDLE: begin
        next_state = ecp_pkg::ECP_HALF;
      end
      ecp_pkg::ECP_HALF: begin
        if (!both_cleared && (cfg.half_duplex_disable || (trained &&
            !cfg.acoustic_coef_clear && measured_return_loss >=
            cfg.acoustic_return_loss_threshold))) begin
          next_state = ecp_pkg::ECP_FULL;
        end
      end
      ecp_pkg::ECP_FULL: begin
        if (both_cleared || retrain_req ||
            (!cfg.half_duplex_disable && cfg.acoustic_coef_clear)) begin
          next_state = ecp_pkg::ECP_HALF;
        end
      end
      default: begin
        next_state = ecp_pkg::ECP_HALF;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ecp_pkg::ECP_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------
  // Outputs to the core, all idle during reset
  // ---------------------------------------------------------------
  logic run;

  assign run = (next_state != ecp_pkg::ECP_IDLE);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= '0; // Low power, every block idle
      return_loss_threshold <= '0;
    end else begin
      ctrl.block_enable <= run;
      ctrl.full_duplex <= (next_state == ecp_pkg::ECP_FULL);
      ctrl.acoustic_adapt <= run && !cfg.acoustic_coef_clear;
      ctrl.network_adapt <= run && !cfg.network_coef_clear &&
                            !cfg.network_ec_disable;
      ctrl.network_ec_enable <= run && !cfg.network_ec_disable;
      ctrl.tx_suppression_enable <= run &&
                                    !cfg.tx_suppression_disable;
      ctrl.rx_suppression_enable <= run &&
                                    !cfg.rx_suppression_disable;
      return_loss_threshold <= cfg.acoustic_return_loss_threshold;
    end
  end

  // ---------------------------------------------------------------
  // Avalon slave: one wait cycle, data registered on the first edge
  // ---------------------------------------------------------------
  logic bus_ack;

  // Fixed two-edge answer keeps the slave simple at no real cost
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_ack <= 1'b0;
      avs_readdata <= '0;
    end else begin
      bus_ack <= (avs_read || avs_write) && !bus_ack;
      if (avs_read && !bus_ack) begin
        case (avs_address)
          ecp_pkg::REG_CONFIG: avs_readdata <= {16'h0000, cfg};
          ecp_pkg::REG_STATUS: begin
            avs_readdata <= {8'h00, frames_taken, utter_cnt, 6'h00, state};
          end
          ecp_pkg::REG_CONTROL: begin
            avs_readdata <= {31'h00000000, port_enable};
          end
          default: avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !bus_ack;

endmodule : ecp_control_port

/* File: verification/ecp_control_port_sva.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Port checker
// ---------------------------------------------------------------
module ecp_control_port_sva (
  input wire logic core_clk, // Core clock
  input wire logic rst_n, // Async reset, active low
  input wire logic data_valid_n, // Transfer gate
  input wire logic [3:0] avs_address, // Bus address
  input wire logic avs_read, // Bus read
  input wire logic avs_write, // Bus write
  input wire logic [31:0] avs_readdata, // Bus read data
  input wire logic avs_waitrequest, // Bus wait
  input wire ecp_pkg::ecp_ctrl_t ctrl, // Core enables
  input wire logic [7:0] return_loss_threshold // Switch level
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Request sitting in its single wait cycle
  sequence s_taken;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  // Both adaptation enables held low for two cycles
  sequence s_both_clear;
    (!ctrl.acoustic_adapt && !ctrl.network_adapt) [*2];
  endsequence
  AST_WAIT_ONE: assert property (s_taken |=> !avs_waitrequest)
    else $error("wait state longer than one cycle");
  AST_WAIT_IDLE: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("wait without a request");
  AST_READ_HOLD: assert property (
    !(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
    else $error("read data moved without a read");
  AST_UNMAPPED: assert property (
    s_taken ##0 (avs_read && avs_address == 4'hC) |=> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  AST_START_HALF: assert property ($rose(rst_n) |=> ctrl.block_enable &&
    !ctrl.full_duplex && return_loss_threshold == 8'h40)
    else $error("bad state after reset release");
  AST_HALF_CLEARED: assert property (s_both_clear |-> !ctrl.full_duplex)
    else $error("full duplex with both sets cleared");
  AST_FULL_ENABLED: assert property (ctrl.full_duplex |-> ctrl.block_enable)
    else $error("full duplex while idle");
  AST_THR_GATED: assert property (
    $changed(return_loss_threshold) |-> data_valid_n)
    else $error("threshold changed inside a transfer");
endmodule : ecp_control_port_sva

bind ecp_control_port ecp_control_port_sva u_ecp_control_port_sva (
  .core_clk(core_clk), .rst_n(rst_n), .data_valid_n(data_valid_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .ctrl(ctrl), .return_loss_threshold(return_loss_threshold));

/* File: verification/ecp_host_model.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Host controller model
// ---------------------------------------------------------------
module ecp_host_model (
  output logic strobe_clk, // Serial strobe, still between frames
  output logic serial_data, // Serial data bit
  output logic data_valid_n // Transfer gate, active low
);
  initial begin
    strobe_clk = 1'b0;
    serial_data = 1'b0;
    data_valid_n = 1'b1;
  end
  // Frame of nb bits MSB first, then nc idle edges to commit
  task automatic send(input logic [15:0] w, input int nb, input int nc);
    logic [15:0] d;
    d = w;
    #1.3; // Keeps strobe phase unrelated to the core clock
    for (int i = 0; i < nb + nc; i++) begin
      data_valid_n = (i >= nb);
      serial_data = (i < nb) ? d[15] : ~serial_data;
      d = {d[14:0], ~d[15]};
      #3 strobe_clk = 1'b1;
      #6 strobe_clk = 1'b0;
      #3;
    end
    serial_data = ~serial_data; // Released line shows no old value
    #40;
  endtask : send
endmodule : ecp_host_model

/* File: verification/tb_ecp_control_port.sv */
`timescale 1ns/1ps
module tb_ecp_control_port;
  logic core_clk = 1'b0;
  logic rst_n, utterance_done, avs_read, avs_write, avs_waitrequest;
  logic strobe_clk, serial_data, data_valid_n;
  logic [7:0] measured_return_loss, return_loss_threshold;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, q;
  ecp_pkg::ecp_ctrl_t ctrl;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  // Core clock, 200 MHz, stands in for the system master clock
  always #2.5 core_clk = ~core_clk;
  ecp_control_port u_ecp_control_port (.core_clk(core_clk), .rst_n(rst_n),
    .strobe_clk(strobe_clk), .serial_data(serial_data),
    .data_valid_n(data_valid_n), .utterance_done(utterance_done),
    .measured_return_loss(measured_return_loss), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ctrl(ctrl), .return_loss_threshold(return_loss_threshold));
  ecp_host_model u_ecp_host_model (.strobe_clk(strobe_clk),
    .serial_data(serial_data), .data_valid_n(data_valid_n));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic stop_test;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask : wt
  // Bus cycle held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) @(posedge core_clk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic frame(input logic [15:0] w, input int nb);
    u_ecp_host_model.send(w, nb, 4);
    wt(12); // Sync and state update settle
  endtask : frame
  task automatic utter(input int n);
    repeat (n) begin
      @(posedge core_clk) utterance_done <= 1'b1;
      @(posedge core_clk) utterance_done <= 1'b0;
    end
  endtask : utter
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    wt(4);
    chk("ctrl in reset", 32'h0, {25'h0, ctrl});
    rst_n <= 1'b1;
    wt(3);
    chk("ctrl after reset", 32'h5F, {25'h0, ctrl});
    chk("threshold", 32'h40, {24'h0, return_loss_threshold});
    bus(1'b0, ecp_pkg::REG_CONFIG, 32'h0);
    chk("config", 32'h4000, q);
    bus(1'b0, ecp_pkg::REG_STATUS, 32'h0);
    chk("state", 32'h1, {30'h0, q[1:0]});
  endtask : t_reset
  task automatic t_disable;
    frame(16'h203C, 16);
    chk("ctrl disables", 32'h70, {25'h0, ctrl});
    chk("threshold", 32'h20, {24'h0, return_loss_threshold});
  endtask : t_disable
  task automatic t_train;
    frame(16'h4003, 16);
    chk("ctrl cleared", 32'h47, {25'h0, ctrl});
    measured_return_loss <= 8'hFF;
    utter(3);
    wt(4);
    chk("cleared duplex", 32'h0, {31'h0, ctrl.full_duplex});
    measured_return_loss <= 8'h3F;
    frame(16'h4002, 16);
    chk("adapt", 32'h1, {31'h0, ctrl.acoustic_adapt});
    utter(3);
    wt(4);
    chk("below level", 32'h0, {31'h0, ctrl.full_duplex});
    measured_return_loss <= 8'h40;
    wt(4);
    chk("trained", 32'h1, {31'h0, ctrl.full_duplex});
  endtask : t_train
  task automatic t_bad;
    frame(16'h1111, 15);
    frame(16'h2222, 17);
    u_ecp_host_model.send(16'h3333, 16, 2);
    wt(12);
    bus(1'b0, ecp_pkg::REG_CONFIG, 32'h0);
    chk("config kept", 32'h4002, q);
    frame(16'h4012, 16);
    bus(1'b0, ecp_pkg::REG_CONFIG, 32'h0);
    chk("config new", 32'h4012, q);
  endtask : t_bad
  task automatic t_bus;
    bus(1'b1, ecp_pkg::REG_CONFIG, 32'h0);
    bus(1'b0, ecp_pkg::REG_CONFIG, 32'h0);
    chk("config read only", 32'h4012, q);
    bus(1'b0, 4'hC, 32'h0);
    chk("unmapped", 32'h0, q);
    bus(1'b1, ecp_pkg::REG_CONTROL, 32'h0);
    frame(16'h4002, 16);
    bus(1'b0, ecp_pkg::REG_CONFIG, 32'h0);
    chk("port off", 32'h4012, q);
    bus(1'b1, ecp_pkg::REG_CONTROL, 32'h1);
    bus(1'b0, ecp_pkg::REG_CONTROL, 32'h0);
    chk("control", 32'h1, q);
  endtask : t_bus
  // Hang guard
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end
  initial begin
    rst_n = 1'b0;
    utterance_done = 1'b0;
    measured_return_loss = 8'h0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_byteenable = 4'hF;
    avs_writedata = 32'h0;
    t_reset();
    t_disable();
    t_train();
    t_bad();
    t_bus();
    stop_test();
  end
endmodule : tb_ecp_control_port
